// [logic/cal_diag_pkg.sv]
// Package with offsets, field positions, reset values and carriers of the bank.
`default_nettype none
package cal_diag_pkg;
   // Register addresses.
   localparam logic [7:0] ADDR_GAIN_UPPER = 8'h24;
   localparam logic [7:0] ADDR_GAIN_MIDDLE = 8'h25;
   localparam logic [7:0] ADDR_GAIN_LOWER = 8'h26;
   localparam logic [7:0] ADDR_SERIAL_EN = 8'h28;
   localparam logic [7:0] ADDR_CONV_EN = 8'h29;
   localparam logic [7:0] ADDR_DIG_EN = 8'h2A;
   localparam logic [7:0] ADDR_RESULT = 8'h2C;
   localparam logic [7:0] ADDR_SERIAL_FLAGS = 8'h2E;
   localparam logic [7:0] ADDR_CONV_FLAGS = 8'h2F;
   localparam logic [7:0] ADDR_DIG_FLAGS = 8'h30;
   localparam logic [7:0] ADDR_CLK_COUNT = 8'h31;

   // Reset values.
   localparam logic [23:0] RST_GAIN = 24'h000000;
   localparam logic [7:0] RST_SERIAL_EN = 8'h10;
   localparam logic [7:0] RST_CONV_EN = 8'h07;
   localparam logic [7:0] RST_DIG_EN = 8'h0D;
   localparam logic [23:0] RST_RESULT = 24'h000000;
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_CLK_COUNT = 8'h00;

   // Writable bits of the mixed-access enable registers.
   localparam logic [7:0] WMASK_SERIAL_EN = 8'h1E;
   localparam logic [7:0] WMASK_CONV_EN = 8'h3F;
   localparam logic [7:0] WMASK_DIG_EN = 8'h1F;

   // Serial-port enable and flag bit positions.
   localparam int BIT_IGNORE = 4;
   localparam int BIT_CLK_CNT = 3;
   localparam int BIT_RD = 2;
   localparam int BIT_WR = 1;
   localparam int BIT_CRC = 0;
   // Converter enable and flag bit positions.
   localparam int BIT_DIG_REG = 5;
   localparam int BIT_ANA_REG = 4;
   localparam int BIT_FILT_SAT = 2;
   localparam int BIT_FILT_NS = 1;
   localparam int BIT_CLK_QUAL = 0;
   // Digital enable and flag bit positions.
   localparam int BIT_REGMAP = 4;
   localparam int BIT_RAM = 3;
   localparam int BIT_FUSE = 2;
   localparam int BIT_PERIOD_CNT = 0;

   // Master clock periods per step of the period counter.
   localparam int CLK_PERIODS_PER_STEP = 64;
   // Gain of 1.0 corresponds to two to this power.
   localparam int GAIN_FRAC_BITS = 22;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic ignore_err;
      logic rd_err;
      logic wr_err;
      logic crc_err;
      logic clk_cnt_err;
      logic dig_reg_err;
      logic ana_reg_err;
      logic filt_sat;
      logic filt_not_settled;
      logic clk_qual_err;
      logic regmap_err;
      logic ram_err;
      logic fuse_err;
   } diag_evt_t;
endpackage
`default_nettype wire

// [logic/cal_diag_regs.sv]
// Gain calibration, diagnostic enable and result register bank.
//
// Overview of operation
// - Gain coefficient in three byte registers 0x24..0x26, read and write.
// - Factory trimmed gain is loaded after reset and reads back.
// - Software writes replace the gain used for later results.
// - Offset is added to the filter output before gain multiplies it.
// - Register 0x28 resets to 0x10; bit 4 ignore check; 7:5,0 read-only.
// - In 0x28 bits 3,2,1 enable clock-count, read, write checks; reset zero.
// - Register 0x29 bits 5,4 enable regulator monitor errors; reset zero.
// - In 0x29 bits 2,1 enable saturation and settling errors; reset 0x07.
// - Bit 0 of 0x29 enables clock qualification, resets one; bit 3 writable.
// - Register 0x2A resets 0x0D; bit 0 counter on; 7:5 fixed; 1 writable.
// - In 0x2A bit 4 regmap check resets 0; bits 3,2 RAM, fuse reset 1.
// - Latest 24-bit result readable at 0x2C, reset zero.
// - Flags at 0x2E: ignore, read, write, checksum clear on write-one.
// - Flags at 0x2F: regulators 5,4, saturation 2, settling 1, clock 0.
// - Enabled period counter advances by one every 64 master clocks.
`timescale 1ns/100ps
`default_nettype none
module cal_diag_regs (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire cal_diag_pkg::reg_req_t reg_req_in,
   input wire logic [23:0] trim_gain_in,
   input wire logic [23:0] user_offset_in,
   input wire logic filter_valid_in,
   input wire logic [23:0] filter_data_in,
   input wire cal_diag_pkg::diag_evt_t diag_evt_in,
   output logic [23:0] reg_rdata_out,
   output logic reg_rvalid_out,
   output logic [23:0] gain_coeff_out,
   output logic [23:0] conv_result_out,
   output logic conv_valid_out,
   output logic [7:0] serial_en_out,
   output logic [7:0] conv_en_out,
   output logic [7:0] dig_en_out
);
   logic trim_pending_ff;
   logic [7:0] serial_flags_ff;
   logic [7:0] conv_flags_ff;
   logic [7:0] dig_flags_ff;
   logic [7:0] clk_count;

   // Address decode.
   wire wr = reg_req_in.wr;
   wire [7:0] wdata = reg_req_in.wdata;
   wire wr_upper = wr && (reg_req_in.addr == cal_diag_pkg::ADDR_GAIN_UPPER);
   wire wr_middle = wr && (reg_req_in.addr == cal_diag_pkg::ADDR_GAIN_MIDDLE);
   wire wr_lower = wr && (reg_req_in.addr == cal_diag_pkg::ADDR_GAIN_LOWER);
   wire wr_serial_en = wr && (reg_req_in.addr == cal_diag_pkg::ADDR_SERIAL_EN);
   wire wr_conv_en = wr && (reg_req_in.addr == cal_diag_pkg::ADDR_CONV_EN);
   wire wr_dig_en = wr && (reg_req_in.addr == cal_diag_pkg::ADDR_DIG_EN);
   wire wr_serial_flags =
      wr && (reg_req_in.addr == cal_diag_pkg::ADDR_SERIAL_FLAGS);

   // Enable registers keep read-only bits at their reset value.
   wire [7:0] nxt_serial_en =
      (wdata & cal_diag_pkg::WMASK_SERIAL_EN) |
      (cal_diag_pkg::RST_SERIAL_EN & ~cal_diag_pkg::WMASK_SERIAL_EN);
   wire [7:0] nxt_conv_en =
      (wdata & cal_diag_pkg::WMASK_CONV_EN) |
      (cal_diag_pkg::RST_CONV_EN & ~cal_diag_pkg::WMASK_CONV_EN);
   wire [7:0] nxt_dig_en =
      (wdata & cal_diag_pkg::WMASK_DIG_EN) |
      (cal_diag_pkg::RST_DIG_EN & ~cal_diag_pkg::WMASK_DIG_EN);

   // The trim is caught one cycle after reset release, never under reset.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         trim_pending_ff <= 1'b1;
      end else begin
         trim_pending_ff <= 1'b0;
      end
   end

   // A software write in the load cycle wins over the trim copy.
   wire [23:0] trim_or_gain = trim_pending_ff ? trim_gain_in : gain_coeff_out;
   wire [23:0] nxt_gain = {
      wr_upper ? wdata : trim_or_gain[23:16],
      wr_middle ? wdata : trim_or_gain[15:8],
      wr_lower ? wdata : trim_or_gain[7:0]
   };

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         gain_coeff_out <= cal_diag_pkg::RST_GAIN;
      end else begin
         gain_coeff_out <= nxt_gain;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         serial_en_out <= cal_diag_pkg::RST_SERIAL_EN;
         conv_en_out <= cal_diag_pkg::RST_CONV_EN;
         dig_en_out <= cal_diag_pkg::RST_DIG_EN;
      end else begin
         if (wr_serial_en) begin
            serial_en_out <= nxt_serial_en;
         end
         if (wr_conv_en) begin
            conv_en_out <= nxt_conv_en;
         end
         if (wr_dig_en) begin
            dig_en_out <= nxt_dig_en;
         end
      end
   end

   // Serial-port flags: events other than the checksum error are gated by their enables; a new event in
   // the cycle of a write-one clear keeps its flag set.
   logic [7:0] serial_set;
   logic [7:0] serial_w1c;
   always_comb begin
      serial_set = 8'h00;
      serial_set[cal_diag_pkg::BIT_IGNORE] = diag_evt_in.ignore_err &&
         serial_en_out[cal_diag_pkg::BIT_IGNORE];
      serial_set[cal_diag_pkg::BIT_RD] = diag_evt_in.rd_err &&
         serial_en_out[cal_diag_pkg::BIT_RD];
      serial_set[cal_diag_pkg::BIT_WR] = diag_evt_in.wr_err &&
         serial_en_out[cal_diag_pkg::BIT_WR];
      serial_set[cal_diag_pkg::BIT_CRC] = diag_evt_in.crc_err;
      serial_w1c = 8'h00;
      serial_w1c[cal_diag_pkg::BIT_IGNORE] = 1'b1;
      serial_w1c[cal_diag_pkg::BIT_RD] = 1'b1;
      serial_w1c[cal_diag_pkg::BIT_WR] = 1'b1;
      serial_w1c[cal_diag_pkg::BIT_CRC] = 1'b1;
   end

   wire [7:0] serial_clr = wr_serial_flags ? (wdata & serial_w1c) : 8'h00;
   wire clk_cnt_level = diag_evt_in.clk_cnt_err &&
      serial_en_out[cal_diag_pkg::BIT_CLK_CNT];
   wire [7:0] sticky_next =
      ((serial_flags_ff & serial_w1c & ~serial_clr) | serial_set);
   logic [7:0] nxt_serial_flags;
   always_comb begin
      nxt_serial_flags = sticky_next;
      nxt_serial_flags[cal_diag_pkg::BIT_CLK_CNT] = clk_cnt_level;
   end

   // Converter and digital flags are read-only levels of the enabled checks.
   logic [7:0] nxt_conv_flags;
   logic [7:0] nxt_dig_flags;
   always_comb begin
      nxt_conv_flags = 8'h00;
      nxt_conv_flags[cal_diag_pkg::BIT_DIG_REG] = diag_evt_in.dig_reg_err &&
         conv_en_out[cal_diag_pkg::BIT_DIG_REG];
      nxt_conv_flags[cal_diag_pkg::BIT_ANA_REG] = diag_evt_in.ana_reg_err &&
         conv_en_out[cal_diag_pkg::BIT_ANA_REG];
      nxt_conv_flags[cal_diag_pkg::BIT_FILT_SAT] = diag_evt_in.filt_sat &&
         conv_en_out[cal_diag_pkg::BIT_FILT_SAT];
      nxt_conv_flags[cal_diag_pkg::BIT_FILT_NS] =
         diag_evt_in.filt_not_settled &&
         conv_en_out[cal_diag_pkg::BIT_FILT_NS];
      nxt_conv_flags[cal_diag_pkg::BIT_CLK_QUAL] = diag_evt_in.clk_qual_err &&
         conv_en_out[cal_diag_pkg::BIT_CLK_QUAL];
      nxt_dig_flags = 8'h00;
      nxt_dig_flags[cal_diag_pkg::BIT_REGMAP] = diag_evt_in.regmap_err &&
         dig_en_out[cal_diag_pkg::BIT_REGMAP];
      nxt_dig_flags[cal_diag_pkg::BIT_RAM] = diag_evt_in.ram_err &&
         dig_en_out[cal_diag_pkg::BIT_RAM];
      nxt_dig_flags[cal_diag_pkg::BIT_FUSE] = diag_evt_in.fuse_err &&
         dig_en_out[cal_diag_pkg::BIT_FUSE];
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         serial_flags_ff <= cal_diag_pkg::RST_FLAGS;
         conv_flags_ff <= cal_diag_pkg::RST_FLAGS;
         dig_flags_ff <= cal_diag_pkg::RST_FLAGS;
      end else begin
         serial_flags_ff <= nxt_serial_flags;
         conv_flags_ff <= nxt_conv_flags;
         dig_flags_ff <= nxt_dig_flags;
      end
   end

   clk_period_counter u_period_counter (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .enable_in(dig_en_out[cal_diag_pkg::BIT_PERIOD_CNT]),
      .count_out(clk_count)
   );

   // Correction: offset first, then gain, with a 2^22 unity point.
   wire signed [24:0] offset_sum = 25'(signed'(filter_data_in)) +
      25'(signed'(user_offset_in));
   wire signed [24:0] gain_signed = signed'({1'b0, gain_coeff_out});
   wire signed [49:0] product = offset_sum * gain_signed;
   wire [27:0] scaled = product[cal_diag_pkg::GAIN_FRAC_BITS +: 28];
   wire fits = (scaled[27:23] == {5{scaled[23]}});
   // Saturation keeps an out-of-range product from wrapping to the other sign.
   wire [23:0] nxt_result = fits ? scaled[23:0] :
      (scaled[27] ? 24'h800000 : 24'h7FFFFF);

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         conv_result_out <= cal_diag_pkg::RST_RESULT;
         conv_valid_out <= 1'b0;
      end else begin
         conv_valid_out <= filter_valid_in;
         if (filter_valid_in) begin
            conv_result_out <= nxt_result;
         end
      end
   end

   // Read mux; unmapped addresses read as zero.
   logic [23:0] rd_mux;
   always_comb begin
      case (reg_req_in.addr)
         cal_diag_pkg::ADDR_GAIN_UPPER:
            rd_mux = {16'h0000, gain_coeff_out[23:16]};
         cal_diag_pkg::ADDR_GAIN_MIDDLE:
            rd_mux = {16'h0000, gain_coeff_out[15:8]};
         cal_diag_pkg::ADDR_GAIN_LOWER:
            rd_mux = {16'h0000, gain_coeff_out[7:0]};
         cal_diag_pkg::ADDR_SERIAL_EN: rd_mux = {16'h0000, serial_en_out};
         cal_diag_pkg::ADDR_CONV_EN: rd_mux = {16'h0000, conv_en_out};
         cal_diag_pkg::ADDR_DIG_EN: rd_mux = {16'h0000, dig_en_out};
         cal_diag_pkg::ADDR_RESULT: rd_mux = conv_result_out;
         cal_diag_pkg::ADDR_SERIAL_FLAGS: rd_mux = {16'h0000, serial_flags_ff};
         cal_diag_pkg::ADDR_CONV_FLAGS: rd_mux = {16'h0000, conv_flags_ff};
         cal_diag_pkg::ADDR_DIG_FLAGS: rd_mux = {16'h0000, dig_flags_ff};
         cal_diag_pkg::ADDR_CLK_COUNT: rd_mux = {16'h0000, clk_count};
         default: rd_mux = 24'h000000;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         reg_rdata_out <= 24'h000000;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_req_in.rd;
         if (reg_req_in.rd) begin
            reg_rdata_out <= rd_mux;
         end
      end
   end
endmodule
`default_nettype wire

// [logic/clk_period_counter.sv]
// Counter that steps once per fixed number of master clock periods.
`timescale 1ns/100ps
`default_nettype none
module clk_period_counter (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic enable_in,
   output logic [7:0] count_out
);
   localparam int PRE_W = $clog2(cal_diag_pkg::CLK_PERIODS_PER_STEP);
   localparam logic [PRE_W-1:0] PRE_LAST =
      PRE_W'(cal_diag_pkg::CLK_PERIODS_PER_STEP - 1);

   logic [PRE_W-1:0] prescale_ff;
   wire step = enable_in && (prescale_ff == PRE_LAST);

   // The prescaler holds while disabled so a re-enable resumes mid-step.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         prescale_ff <= '0;
         count_out <= cal_diag_pkg::RST_CLK_COUNT;
      end else if (enable_in) begin
         prescale_ff <= prescale_ff + PRE_W'(1);
         if (step) begin
            count_out <= count_out + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// [sim/cal_diag_checker.sv]
// Port-level concurrent checks for the calibration and diagnostic bank.
`timescale 1ns/100ps
`default_nettype none
module cal_diag_checker (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire cal_diag_pkg::reg_req_t reg_req_in,
   input wire logic filter_valid_in,
   input wire logic [23:0] reg_rdata_out,
   input wire logic reg_rvalid_out,
   input wire logic [23:0] gain_coeff_out,
   input wire logic [23:0] conv_result_out,
   input wire logic conv_valid_out,
   input wire logic [7:0] serial_en_out,
   input wire logic [7:0] conv_en_out,
   input wire logic [7:0] dig_en_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   sequence wr_at(logic [7:0] a);
      reg_req_in.wr && reg_req_in.addr == a;
   endsequence
   sequence rd_at(logic [7:0] a);
      reg_req_in.rd && reg_req_in.addr == a;
   endsequence
   rst_vals_a: assert property (disable iff (1'b0)
      sys_rst_in |=> serial_en_out == 8'h10 && conv_en_out == 8'h07 &&
      dig_en_out == 8'h0D && conv_result_out == 24'h000000)
      else $error("reset value wrong");
   ro_bits_a: assert property (serial_en_out[7:5] == 3'h0 &&
      !serial_en_out[0] && conv_en_out[7:6] == 2'h0 && dig_en_out[7:5] == 3'h0)
      else $error("read-only enable bit changed");
   gain_upper_a: assert property (wr_at(8'h24) |=>
      gain_coeff_out[23:16] == $past(reg_req_in.wdata))
      else $error("gain upper byte not written");
   gain_lower_a: assert property (wr_at(8'h26) |=>
      gain_coeff_out[7:0] == $past(reg_req_in.wdata))
      else $error("gain lower byte not written");
   conv_en_a: assert property (wr_at(8'h29) |=>
      conv_en_out == ($past(reg_req_in.wdata) & 8'h3F))
      else $error("converter enable write wrong");
   dig_en_a: assert property (wr_at(8'h2A) |=>
      dig_en_out == ($past(reg_req_in.wdata) & 8'h1F))
      else $error("digital enable write wrong");
   serial_hold_a: assert property (
      !(reg_req_in.wr && reg_req_in.addr == 8'h28) |=> $stable(serial_en_out))
      else $error("serial enables changed without write");
   rvalid_pulse_a: assert property (1'b1 |=>
      reg_rvalid_out == $past(reg_req_in.rd))
      else $error("read valid timing wrong");
   result_read_a: assert property (rd_at(8'h2C) |=>
      reg_rdata_out == $past(conv_result_out))
      else $error("result read mismatch");
   result_hold_a: assert property (!filter_valid_in |=>
      !conv_valid_out && $stable(conv_result_out))
      else $error("result changed without filter data");
endmodule
bind cal_diag_regs cal_diag_checker u_cal_diag_checker (.clk_in, .sys_rst_in,
   .reg_req_in, .filter_valid_in, .reg_rdata_out, .reg_rvalid_out,
   .gain_coeff_out, .conv_result_out, .conv_valid_out, .serial_en_out,
   .conv_en_out, .dig_en_out);
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the calibration and diagnostic register bank.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   cal_diag_pkg::reg_req_t req = '0;
   cal_diag_pkg::diag_evt_t evt = '0;
   logic [23:0] trim = 24'h55A6C3;
   logic [23:0] offs = 24'h000000;
   logic [23:0] fdata = 24'h000000;
   logic fvalid = 1'b0;
   logic [23:0] rdata, gain, result, got, gv, d, o;
   logic rvalid, cvalid;
   logic [7:0] sen, cen, den, w, e, e2, c0;
   logic [31:0] seed = 32'hC3C956D7;
   int bad_count = 0;
   int tests_run = 0;
   int cycles = 0;
   cal_diag_regs u_cal_diag_regs (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .reg_req_in(req), .trim_gain_in(trim), .user_offset_in(offs),
      .filter_valid_in(fvalid), .filter_data_in(fdata), .diag_evt_in(evt),
      .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .gain_coeff_out(gain),
      .conv_result_out(result), .conv_valid_out(cvalid),
      .serial_en_out(sen), .conv_en_out(cen), .dig_en_out(den));
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count = bad_count + 1;
         end_sim();
      end
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Offset is summed before the gain multiplies, then the result clips.
   function automatic logic [23:0] exp_res(input logic [23:0] d, o, g);
      longint p;
      p = (longint'($signed(d)) + longint'($signed(o))) * longint'(g);
      p = p >>> 22;
      if (p > 64'sh7FFFFF) p = 64'sh7FFFFF;
      if (p < -64'sh800000) p = -64'sh800000;
      return p[23:0];
   endfunction
   task automatic check(input logic [23:0] g, input logic [23:0] x);
      tests_run = tests_run + 1;
      if (g !== x) begin
         bad_count = bad_count + 1;
         $display("ERROR %0t got %h expected %h", $time, g, x);
      end
   endtask
   task automatic acc(input logic wr, rd, input logic [7:0] a, dt);
      @(negedge clk_in);
      req = '{wr: wr, rd: rd, addr: a, wdata: dt};
      @(negedge clk_in);
      req = '0;
      got = rdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [23:0] x);
      acc(1'b0, 1'b1, a, 8'h00);
      check({23'h0, rvalid}, 24'h000001);
      check(got, x);
   endtask
   task automatic end_sim();
      if (bad_count == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge clk_in);
      sys_rst_in = 1'b0;
      for (int k = 0; k < 2; k++) begin
         check({sen, cen, den}, 24'h10070D);
         rdchk(8'h28, 24'h000010);
         rdchk(8'h29, 24'h000007);
         rdchk(8'h2A, 24'h00000D);
         acc(1'b1, 1'b0, 8'h2C, 8'hFF);
         rdchk(8'h2C, 24'h000000);
         rdchk(8'h24, 24'h000055);
         rdchk(8'h25, 24'h0000A6);
         rdchk(8'h26, 24'h0000C3);
         acc(1'b1, 1'b0, 8'h27, 8'hFF);
         rdchk(8'h27, 24'h000000);
         for (int i = 0; i < 6; i++) begin
            w = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'(rnd());
            acc(1'b1, 1'b0, 8'h28, w);
            acc(1'b1, 1'b0, 8'h29, w);
            acc(1'b1, 1'b0, 8'h2A, w);
            rdchk(8'h28, {16'h0000, w & 8'h1E});
            rdchk(8'h29, {16'h0000, w & 8'h3F});
            rdchk(8'h2A, {16'h0000, w & 8'h1F});
            check({sen, cen, den}, {w & 8'h1E, w & 8'h3F, w & 8'h1F});
         end
         sys_rst_in = 1'b1;
         repeat (2) @(negedge clk_in);
         sys_rst_in = 1'b0;
      end
      for (int i = 0; i < 10; i++) begin
         gv = (i < 2) ? 24'hFFFFFF : (24'(rnd()) & 24'h7FFFFF);
         d = (i == 0) ? 24'h7FFFFF : (i == 1) ? 24'h800000 : 24'(rnd());
         o = (i < 2) ? d : 24'(rnd());
         // Random data stays in range; the two corners drive both clips.
         if (i >= 2) begin
            d = {{2{d[21]}}, d[21:0]};
            o = {{2{o[21]}}, o[21:0]};
         end
         for (int b = 0; b < 3; b++) begin
            acc(1'b1, 1'b0, 8'(8'h24 + b), 8'(gv >> (16 - 8 * b)));
            rdchk(8'(8'h24 + b), {16'h0000, 8'(gv >> (16 - 8 * b))});
         end
         check(gain, gv);
         @(negedge clk_in);
         fvalid = 1'b1;
         fdata = d;
         offs = o;
         @(negedge clk_in);
         fvalid = 1'b0;
         check({23'h0, cvalid}, 24'h000001);
         check(result, exp_res(d, o, gv));
         rdchk(8'h2C, exp_res(d, o, gv));
      end
      for (int en = 1; en >= 0; en--) begin
         acc(1'b1, 1'b0, 8'h28, en ? 8'h1E : 8'h00);
         @(negedge clk_in);
         evt = '{ignore_err: 1'b1, rd_err: 1'b1, wr_err: 1'b1, crc_err: 1'b1,
            clk_cnt_err: 1'b1, default: 1'b0};
         @(negedge clk_in);
         evt = '{clk_cnt_err: 1'b1, default: 1'b0};
         rdchk(8'h2E, en ? 24'h00001F : 24'h000001);
         // A read error in the clear cycle must keep its flag set.
         evt = '{rd_err: 1'b1, default: 1'b0};
         acc(1'b1, 1'b0, 8'h2E, 8'h17);
         evt = '0;
         rdchk(8'h2E, en ? 24'h000004 : 24'h000000);
         acc(1'b1, 1'b0, 8'h2E, 8'h04);
         rdchk(8'h2E, 24'h000000);
      end
      for (int i = 0; i < 8; i++) begin
         w = 8'(rnd());
         e = 8'(rnd());
         e2 = 8'(rnd());
         acc(1'b1, 1'b0, 8'h29, e);
         acc(1'b1, 1'b0, 8'h2A, e2 | 8'h01);
         evt = '{dig_reg_err: w[5], ana_reg_err: w[4], filt_sat: w[2],
            filt_not_settled: w[1], clk_qual_err: w[0], regmap_err: w[4],
            ram_err: w[3], fuse_err: w[2], default: 1'b0};
         rdchk(8'h2F, {16'h0000, w & e & 8'h37});
         rdchk(8'h30, {16'h0000, w & e2 & 8'h1C});
      end
      evt = '0;
      acc(1'b1, 1'b0, 8'h2A, 8'h0C);
      acc(1'b0, 1'b1, 8'h31, 8'h00);
      c0 = got[7:0];
      repeat (200) @(negedge clk_in);
      rdchk(8'h31, {16'h0000, c0});
      acc(1'b1, 1'b0, 8'h2A, 8'h0D);
      acc(1'b0, 1'b1, 8'h31, 8'h00);
      c0 = got[7:0];
      // Reads 256 cycles apart see exactly four steps whatever the phase.
      repeat (254) @(negedge clk_in);
      rdchk(8'h31, {16'h0000, 8'(c0 + 8'h04)});
      end_sim();
   end
endmodule
`default_nettype wire
